// File: ides_exec_core.sv
// The implementer's own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// RQ1 - decrement-and-skip subtracts one from file 0..127, flags untouched
// RQ2 - destination bit 0 sends file-operation result to accumulator
// RQ3 - destination bit 1 writes result back to the addressed file
// RQ4 - decrement-and-skip zero result skips next word, two cycles
// RQ5 - increment-and-skip adds one, routes result, skips on zero, no flags
// RQ6 - plain increment adds one, routes result, updates zero flag
// RQ7 - jump loads 11-bit literal into pc 10..0, two cycles
// RQ8 - jump fills pc 12..11 from upper latch bits 4..3
// RQ9 - or-literal ors accumulator with 8-bit literal, updates zero flag
// RQ10 - or-file ors accumulator with file, routes result, updates zero
// RQ11 - wake by interrupt with global enable loads vector into pc
// RQ12 - wake-up events set interrupt flag bits, which cause the wake
// RQ13 - unimplemented bits read zero; software keeps reserved bits clear
// RQ14 - one instruction cycle spans four oscillator periods
// RQ15 - zero flag follows 8-bit result only for flag-affecting operations
// RQ16 - increment and decrement wrap modulo 256
module ides_exec_core #(
    parameter int CYC_DIV = ides_pkg::OSC_PER_CYC
) (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic [5:0] addr_i,
    input wire logic [31:0] wr_data_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rd_data_o,
    input wire logic [ides_pkg::EVT_W-1:0] evt_i,
    output logic [12:0] pc_o,
    output logic busy_o,
    output logic asleep_o
);
    localparam logic [7:0] DIV_LAST = 8'(CYC_DIV - 1);
    localparam int EW = ides_pkg::EVT_W;

    generate
        if (CYC_DIV < 2 || CYC_DIV > 256) begin : g_bad_div
            $error("CYC_DIV must lie in 2..256");
        end
    endgenerate

    typedef struct packed {
        logic [7:0] cdiv;
        logic cyc_en;
        ides_pkg::ides_state_t st;
        logic [31:0] instr;
        logic [7:0] acc;
        logic z;
        logic [12:0] pc;
        logic [4:0] pchi;
        logic [6:0] faddr;
        logic global_irq_enable;
        logic [7:0] pira;
        logic pirb;
        logic [EW-1:0] s1;
        logic [EW-1:0] s2;
        logic [EW-1:0] s3;
        logic [EW-1:0] lvl;
        logic [31:0] rdata;
        logic busy;
        logic asleep;
        logic [127:0][7:0] fmem;
    } ides_regs_t;

    ides_regs_t r;
    ides_regs_t n;

    function automatic logic reg_hit(input logic [5:0] a,
                                     input logic [5:0] off);
        reg_hit = (a == off);
    endfunction : reg_hit

    ides_pkg::ides_op_t op;
    logic dest_file;
    logic [6:0] fsel;
    logic [10:0] klit;
    logic [7:0] fval;
    logic [7:0] res;
    logic res_zero;
    logic exec;
    logic pend;
    logic [EW-1:0] agree;
    logic [EW-1:0] rise;

    assign op = ides_pkg::ides_op_t'(r.instr[ides_pkg::INSTR_OP_LSB +: 3]);
    assign dest_file = r.instr[ides_pkg::INSTR_D_BIT];
    assign fsel = r.instr[ides_pkg::INSTR_F_LSB +: 7];
    assign klit = r.instr[ides_pkg::INSTR_K_LSB +: 11];
    assign fval = r.fmem[fsel];
    assign res_zero = (res == 8'h00);
    assign exec = r.cyc_en && (r.st == ides_pkg::ST_WAIT);
    assign pend = (|r.pira) | r.pirb;
    assign agree = ~(r.s2 ^ r.s3);
    assign rise = agree & r.s3 & ~r.lvl;

    // result of the operation held in the instruction register
    always_comb begin
        case (op)
            // RQ1 decrement, 8-bit wrap
            // RQ16 modulo 256
            ides_pkg::OP_DEC_SKIP: res = fval - 8'h01;
            // RQ5 increment, 8-bit wrap
            ides_pkg::OP_INC_SKIP: res = fval + 8'h01;
            // RQ6 plain increment
            ides_pkg::OP_INC: res = fval + 8'h01;
            // RQ9 or with literal
            ides_pkg::OP_OR_LIT: res = r.acc | klit[7:0];
            // RQ10 or with file
            ides_pkg::OP_OR_FILE: res = r.acc | fval;
            default: res = 8'h00;
        endcase
    end

    always_comb begin
        n = r;
        // RQ14 four-period cycle enable
        n.cyc_en = 1'b0;
        if (r.cdiv == DIV_LAST) begin
            n.cdiv = 8'h00;
            n.cyc_en = 1'b1;
        end else begin
            n.cdiv = r.cdiv + 8'h01;
        end
        // event pins: three stages, accepted when stages two and three agree
        n.s1 = evt_i;
        n.s2 = r.s1;
        n.s3 = r.s2;
        n.lvl = (agree & r.s3) | (~agree & r.lvl);

        // register writes
        if (wr_i) begin
            if (reg_hit(addr_i, ides_pkg::REG_INSTR)) begin
                if (r.st == ides_pkg::ST_IDLE) begin
                    n.instr = wr_data_i;
                    n.st = ides_pkg::ST_WAIT;
                end
            end
            if (reg_hit(addr_i, ides_pkg::REG_ACC)) begin
                n.acc = wr_data_i[7:0];
            end
            if (reg_hit(addr_i, ides_pkg::REG_STATUS)) begin
                n.z = wr_data_i[ides_pkg::ST_Z_BIT];
            end
            if (reg_hit(addr_i, ides_pkg::REG_PC)) begin
                n.pc = wr_data_i[12:0];
            end
            if (reg_hit(addr_i, ides_pkg::REG_PCHI)) begin
                n.pchi = wr_data_i[4:0];
            end
            if (reg_hit(addr_i, ides_pkg::REG_FADDR)) begin
                n.faddr = wr_data_i[6:0];
            end
            if (reg_hit(addr_i, ides_pkg::REG_FDATA)) begin
                n.fmem[r.faddr] = wr_data_i[7:0];
            end
            if (reg_hit(addr_i, ides_pkg::REG_IRQCTL)) begin
                n.global_irq_enable = wr_data_i[ides_pkg::IRQ_GIE_BIT];
            end
            // flags clear by writing one
            if (reg_hit(addr_i, ides_pkg::REG_PIRA)) begin
                n.pira = r.pira & ~wr_data_i[7:0];
            end
            if (reg_hit(addr_i, ides_pkg::REG_PIRB)) begin
                n.pirb = r.pirb & ~wr_data_i[0];
            end
        end
        // RQ12 events set flags, set wins over clear
        n.pira = n.pira | rise[7:0];
        n.pirb = n.pirb | rise[8];

        // register reads, data valid the next cycle only
        n.rdata = 32'h0000_0000;
        if (rd_i) begin
            // RQ13 unimplemented bits read zero
            if (reg_hit(addr_i, ides_pkg::REG_INSTR)) begin
                n.rdata = r.instr;
            end else if (reg_hit(addr_i, ides_pkg::REG_ACC)) begin
                n.rdata = {24'h000000, r.acc};
            end else if (reg_hit(addr_i, ides_pkg::REG_STATUS)) begin
                n.rdata[ides_pkg::ST_Z_BIT] = r.z;
                n.rdata[ides_pkg::ST_BUSY_BIT] = r.busy;
                n.rdata[ides_pkg::ST_SLEEP_BIT] = r.asleep;
            end else if (reg_hit(addr_i, ides_pkg::REG_PC)) begin
                n.rdata = {19'h00000, r.pc};
            end else if (reg_hit(addr_i, ides_pkg::REG_PCHI)) begin
                n.rdata = {27'h0000000, r.pchi};
            end else if (reg_hit(addr_i, ides_pkg::REG_FADDR)) begin
                n.rdata = {25'h0000000, r.faddr};
            end else if (reg_hit(addr_i, ides_pkg::REG_FDATA)) begin
                n.rdata = {24'h000000, r.fmem[r.faddr]};
            end else if (reg_hit(addr_i, ides_pkg::REG_IRQCTL)) begin
                n.rdata[ides_pkg::IRQ_GIE_BIT] = r.global_irq_enable;
                n.rdata[ides_pkg::IRQ_PEND_BIT] = pend;
            end else if (reg_hit(addr_i, ides_pkg::REG_PIRA)) begin
                n.rdata = {24'h000000, r.pira};
            end else if (reg_hit(addr_i, ides_pkg::REG_PIRB)) begin
                n.rdata = {31'h00000000, r.pirb};
            end
        end

        // execution, one step per instruction cycle
        case (r.st)
            ides_pkg::ST_IDLE: begin
            end
            ides_pkg::ST_WAIT: begin
                if (r.cyc_en) begin
                    n.pc = r.pc + 13'h0001;
                    n.st = ides_pkg::ST_IDLE;
                    case (op)
                        ides_pkg::OP_DEC_SKIP, ides_pkg::OP_INC_SKIP,
                        ides_pkg::OP_INC, ides_pkg::OP_OR_FILE: begin
                            // RQ3 back to the file
                            if (dest_file) begin
                                n.fmem[fsel] = res;
                            // RQ2 into the accumulator
                            end else begin
                                n.acc = res;
                            end
                            // RQ15 zero flag only for flag-affecting ops
                            if (op == ides_pkg::OP_INC ||
                                op == ides_pkg::OP_OR_FILE) begin
                                n.z = res_zero;
                            end
                            // RQ4 zero result skips the next word
                            if (op != ides_pkg::OP_INC &&
                                op != ides_pkg::OP_OR_FILE && res_zero) begin
                                n.pc = r.pc + 13'h0002;
                                n.st = ides_pkg::ST_SECOND;
                            end
                        end
                        ides_pkg::OP_OR_LIT: begin
                            n.acc = res;
                            n.z = res_zero;
                        end
                        ides_pkg::OP_JUMP: begin
                            // RQ7 literal to low pc
                            // RQ8 latch bits to high pc
                            n.pc = {r.pchi[ides_pkg::PCHI_SEL_LSB +: 2], klit};
                            n.st = ides_pkg::ST_SECOND;
                        end
                        ides_pkg::OP_SLEEP: begin
                            n.st = ides_pkg::ST_SLEEP;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            ides_pkg::ST_SECOND: begin
                if (r.cyc_en) begin
                    n.st = ides_pkg::ST_IDLE;
                end
            end
            ides_pkg::ST_SLEEP: begin
                if (r.cyc_en && pend) begin
                    n.st = ides_pkg::ST_IDLE;
                    // RQ11 vector on wake
                    if (r.global_irq_enable) begin
                        n.pc = ides_pkg::IRQ_VECTOR;
                    end
                end
            end
            default: n.st = ides_pkg::ST_IDLE;
        endcase
        n.busy = (n.st != ides_pkg::ST_IDLE);
        n.asleep = (n.st == ides_pkg::ST_SLEEP);
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            r <= '0;
            r.st <= ides_pkg::ST_IDLE;
            r.pc <= ides_pkg::PC_RST;
            r.acc <= ides_pkg::ACC_RST;
            r.pchi <= ides_pkg::PCHI_RST;
            r.global_irq_enable <= ides_pkg::IRQ_GIE_RST;
            r.z <= ides_pkg::Z_RST;
        end else begin
            r <= n;
        end
    end

    assign rd_data_o = r.rdata;
    assign pc_o = r.pc;
    assign busy_o = r.busy;
    assign asleep_o = r.asleep;

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!resetn_i);

    sequence s_second_cycle;
        (r.st == ides_pkg::ST_SECOND) [*4] ##1 (r.st == ides_pkg::ST_IDLE);
    endsequence

    sequence s_skip_exec;
        exec && res_zero && (op == ides_pkg::OP_DEC_SKIP ||
                             op == ides_pkg::OP_INC_SKIP);
    endsequence

    AST_CYC_PERIOD: assert property ( // RQ14
        r.cyc_en |=> !r.cyc_en [*3] ##1 r.cyc_en)
        else $error("instruction cycle is not four clocks");

    AST_SKIP_FLAGS: assert property ( // RQ1
        exec && !(wr_i && reg_hit(addr_i, ides_pkg::REG_STATUS)) &&
        (op == ides_pkg::OP_DEC_SKIP || op == ides_pkg::OP_INC_SKIP)
        |=> r.z == $past(r.z))
        else $error("skip instruction altered zero flag");

    AST_DEST_ACC: assert property ( // RQ2
        exec && !dest_file && op != ides_pkg::OP_JUMP &&
        op != ides_pkg::OP_SLEEP && op != ides_pkg::OP_NOP
        |=> r.acc == $past(res))
        else $error("result not in accumulator");

    AST_DEST_FILE: assert property ( // RQ3
        exec && dest_file && op != ides_pkg::OP_OR_LIT &&
        op != ides_pkg::OP_JUMP && op != ides_pkg::OP_SLEEP &&
        op != ides_pkg::OP_NOP
        |=> r.fmem[$past(fsel)] == $past(res))
        else $error("result not written to file");

    AST_SKIP_TWO: assert property ( // RQ4
        s_skip_exec |=> (r.pc == $past(r.pc) + 13'h0002) ##0 s_second_cycle)
        else $error("skip did not take two cycles");

    AST_NO_SKIP: assert property ( // RQ5
        exec && !res_zero && op == ides_pkg::OP_INC_SKIP
        |=> r.pc == $past(r.pc) + 13'h0001 && r.st == ides_pkg::ST_IDLE)
        else $error("nonzero increment-and-skip skipped");

    AST_Z_UPDATE: assert property ( // RQ6
        exec && (op == ides_pkg::OP_INC || op == ides_pkg::OP_OR_LIT ||
                 op == ides_pkg::OP_OR_FILE)
        |=> r.z == ($past(res) == 8'h00))
        else $error("zero flag does not follow result");

    AST_JUMP_PC: assert property ( // RQ8
        exec && op == ides_pkg::OP_JUMP
        |=> r.pc == {$past(r.pchi[4:3]), $past(klit)} ##0 s_second_cycle)
        else $error("jump target or length wrong");

    AST_WAKE_VEC: assert property ( // RQ11
        r.st == ides_pkg::ST_SLEEP && r.cyc_en && pend && r.global_irq_enable
        |=> r.pc == ides_pkg::IRQ_VECTOR && !r.asleep)
        else $error("wake did not vector");

    AST_FLAG_SET: assert property ( // RQ12
        (|rise[7:0]) |=> (r.pira & $past(rise[7:0])) == $past(rise[7:0]))
        else $error("event did not set flag");

    AST_RSVD_ZERO: assert property ( // RQ13
        rd_i && reg_hit(addr_i, ides_pkg::REG_PCHI)
        |=> rd_data_o[31:5] == 27'h0000000)
        else $error("unimplemented bits read nonzero");

    AST_WRAP: assert property ( // RQ16
        exec && op == ides_pkg::OP_INC && fval == 8'hFF |=> r.z)
        else $error("increment of 255 did not wrap");
endmodule : ides_exec_core

`default_nettype wire

// File: ides_exec_core_bench.sv
`timescale 1ns/1ps
`default_nettype none

module ides_exec_core_bench;
    logic mclk_i;
    logic resetn_i;
    logic [5:0] addr_i;
    logic [31:0] wr_data_i;
    logic wr_i;
    logic rd_i;
    logic [31:0] rd_data_o;
    logic [ides_pkg::EVT_W-1:0] evt_i;
    logic [12:0] pc_o;
    logic busy_o;
    logic asleep_o;
    logic [12:0] pc0;
    int err_count;
    int comparisons;

    ides_exec_core #(.CYC_DIV(4)) dut (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .addr_i(addr_i),
        .wr_data_i(wr_data_i),
        .wr_i(wr_i),
        .rd_i(rd_i),
        .rd_data_o(rd_data_o),
        .evt_i(evt_i),
        .pc_o(pc_o),
        .busy_o(busy_o),
        .asleep_o(asleep_o)
    );

    initial begin
        mclk_i = 1'b0;
        forever #4 mclk_i = ~mclk_i;
    end

    task automatic stop_test();
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : stop_test

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        wr_data_i <= d;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
        #1;
    endtask : wr

    task automatic rchk(input logic [5:0] a, input logic [31:0] e,
                        input string name);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1;
        check(name, rd_data_o, e);
    endtask : rchk

    task automatic setf(input logic [6:0] f, input logic [7:0] v);
        wr(ides_pkg::REG_FADDR, {25'h0, f});
        wr(ides_pkg::REG_FDATA, {24'h0, v});
    endtask : setf

    task automatic chkf(input logic [6:0] f, input logic [7:0] e);
        wr(ides_pkg::REG_FADDR, {25'h0, f});
        rchk(ides_pkg::REG_FDATA, {24'h0, e}, "file");
    endtask : chkf

    task automatic pcchk(input logic [12:0] e);
        check("pc", {19'h0, pc_o}, {19'h0, e});
    endtask : pcchk

    function automatic logic [31:0] ins(input logic [2:0] op, input logic d,
                                        input logic [6:0] f,
                                        input logic [10:0] k);
        ins = {5'h00, k, 1'b0, f, 3'h0, d, 1'b0, op};
    endfunction : ins

    // gap: clocks from the pc update to busy falling
    task automatic exec(input logic [31:0] w, input int gap);
        int i;
        int tpc;
        tpc = -1;
        pc0 = pc_o;
        wr(ides_pkg::REG_INSTR, w);
        i = 0;
        while (busy_o !== 1'b1 && i < 20) begin
            @(posedge mclk_i);
            #1;
            i++;
        end
        if (i == 20) begin
            err_count++;
            stop_test();
        end
        i = 0;
        while (busy_o !== 1'b0 && i < 40) begin
            @(posedge mclk_i);
            #1;
            i++;
            if (tpc < 0 && pc_o !== pc0) tpc = i;
        end
        if (i == 40) begin
            err_count++;
            stop_test();
        end
        check("cycle gap", 32'(i - tpc), 32'(gap));
    endtask : exec

    task automatic wait_sleep(input logic lvl);
        int i;
        i = 0;
        while (asleep_o !== lvl && i < 100) begin
            @(posedge mclk_i);
            #1;
            i++;
        end
        if (i == 100) begin
            err_count++;
            stop_test();
        end
    endtask : wait_sleep

    initial begin
        resetn_i = 1'b0;
        wr_i = 1'b0;
        rd_i = 1'b0;
        addr_i = 6'h00;
        wr_data_i = 32'h0000_0000;
        evt_i = '0;
        err_count = 0;
        comparisons = 0;
        repeat (10) @(posedge mclk_i);
        resetn_i <= 1'b1;
        rchk(ides_pkg::REG_STATUS, 32'h0, "status");
        pcchk(ides_pkg::PC_RST);
        rchk(6'h28, 32'h0, "unmapped");
        wr(ides_pkg::REG_ACC, 32'hFFFF_FFFF);
        rchk(ides_pkg::REG_ACC, 32'h0000_00FF, "acc bits");
        wr(ides_pkg::REG_PCHI, 32'hFFFF_FFFF);
        rchk(ides_pkg::REG_PCHI, 32'h0000_001F, "pchi bits");
        // increment wraps into the file
        setf(7'h7F, 8'hFF);
        wr(ides_pkg::REG_ACC, 32'h33);
        exec(ins(ides_pkg::OP_INC, 1'b1, 7'h7F, 11'h0), 0);
        pcchk(pc0 + 13'h1);
        chkf(7'h7F, 8'h00);
        rchk(ides_pkg::REG_STATUS, 32'h1, "zero");
        rchk(ides_pkg::REG_ACC, 32'h33, "acc");
        setf(7'h05, 8'h41);
        exec(ins(ides_pkg::OP_INC, 1'b0, 7'h05, 11'h0), 0);
        rchk(ides_pkg::REG_ACC, 32'h42, "acc");
        chkf(7'h05, 8'h41);
        rchk(ides_pkg::REG_STATUS, 32'h0, "zero");
        // decrement to zero skips, flag untouched
        setf(7'h03, 8'h01);
        exec(ins(ides_pkg::OP_DEC_SKIP, 1'b1, 7'h03, 11'h0), 4);
        pcchk(pc0 + 13'h2);
        chkf(7'h03, 8'h00);
        rchk(ides_pkg::REG_STATUS, 32'h0, "zero");
        wr(ides_pkg::REG_STATUS, 32'h1);
        exec(ins(ides_pkg::OP_DEC_SKIP, 1'b0, 7'h03, 11'h0), 0);
        pcchk(pc0 + 13'h1);
        rchk(ides_pkg::REG_ACC, 32'hFF, "acc");
        chkf(7'h03, 8'h00);
        rchk(ides_pkg::REG_STATUS, 32'h1, "zero");
        // increment-and-skip both ways
        setf(7'h09, 8'hFF);
        exec(ins(ides_pkg::OP_INC_SKIP, 1'b1, 7'h09, 11'h0), 4);
        pcchk(pc0 + 13'h2);
        chkf(7'h09, 8'h00);
        exec(ins(ides_pkg::OP_INC_SKIP, 1'b0, 7'h09, 11'h0), 0);
        pcchk(pc0 + 13'h1);
        rchk(ides_pkg::REG_ACC, 32'h01, "acc");
        rchk(ides_pkg::REG_STATUS, 32'h1, "zero");
        // or with literal
        wr(ides_pkg::REG_ACC, 32'h50);
        exec(ins(ides_pkg::OP_OR_LIT, 1'b0, 7'h00, 11'h0A), 0);
        rchk(ides_pkg::REG_ACC, 32'h5A, "acc");
        rchk(ides_pkg::REG_STATUS, 32'h0, "zero");
        wr(ides_pkg::REG_ACC, 32'h00);
        exec(ins(ides_pkg::OP_OR_LIT, 1'b0, 7'h00, 11'h00), 0);
        rchk(ides_pkg::REG_STATUS, 32'h1, "zero");
        // or with file
        wr(ides_pkg::REG_ACC, 32'h0F);
        setf(7'h40, 8'hF0);
        exec(ins(ides_pkg::OP_OR_FILE, 1'b1, 7'h40, 11'h0), 0);
        chkf(7'h40, 8'hFF);
        rchk(ides_pkg::REG_ACC, 32'h0F, "acc");
        rchk(ides_pkg::REG_STATUS, 32'h0, "zero");
        wr(ides_pkg::REG_ACC, 32'h00);
        setf(7'h41, 8'h00);
        exec(ins(ides_pkg::OP_OR_FILE, 1'b0, 7'h41, 11'h0), 0);
        rchk(ides_pkg::REG_STATUS, 32'h1, "zero");
        // jump with upper latch bits
        wr(ides_pkg::REG_PCHI, 32'h18);
        exec(ins(ides_pkg::OP_JUMP, 1'b0, 7'h00, 11'h7FF), 4);
        pcchk(13'h1FFF);
        wr(ides_pkg::REG_PCHI, 32'h0F);
        exec(ins(ides_pkg::OP_JUMP, 1'b0, 7'h00, 11'h123), 4);
        pcchk(13'h0923);
        // sleep, wake with global enable, refused write while busy
        wr(ides_pkg::REG_ACC, 32'h11);
        wr(ides_pkg::REG_IRQCTL, 32'h80);
        wr(ides_pkg::REG_INSTR, ins(ides_pkg::OP_SLEEP, 1'b0, 7'h0, 11'h0));
        wait_sleep(1'b1);
        check("pins", {30'h0, busy_o, asleep_o}, 32'h3);
        rchk(ides_pkg::REG_STATUS, 32'h7, "status");
        wr(ides_pkg::REG_INSTR, ins(ides_pkg::OP_OR_LIT, 1'b0, 7'h0, 11'hFF));
        @(posedge mclk_i);
        evt_i <= 9'h004;
        wait_sleep(1'b0);
        pcchk(ides_pkg::IRQ_VECTOR);
        check("pins", {30'h0, busy_o, asleep_o}, 32'h0);
        rchk(ides_pkg::REG_PIRA, 32'h04, "flags a");
        rchk(ides_pkg::REG_IRQCTL, 32'h81, "irqctl");
        rchk(ides_pkg::REG_ACC, 32'h11, "acc");
        @(posedge mclk_i);
        evt_i <= 9'h000;
        wr(ides_pkg::REG_PIRA, 32'h04);
        rchk(ides_pkg::REG_IRQCTL, 32'h80, "irqctl");
        // wake without global enable keeps the pc
        wr(ides_pkg::REG_IRQCTL, 32'h00);
        pc0 = pc_o;
        wr(ides_pkg::REG_INSTR, ins(ides_pkg::OP_SLEEP, 1'b0, 7'h0, 11'h0));
        wait_sleep(1'b1);
        @(posedge mclk_i);
        evt_i <= 9'h100;
        wait_sleep(1'b0);
        pcchk(pc0 + 13'h1);
        rchk(ides_pkg::REG_PIRB, 32'h01, "flags b");
        stop_test();
    end
endmodule : ides_exec_core_bench

`default_nettype wire

// File: ides_pkg.sv
`default_nettype none

package ides_pkg;
    // register offsets (byte addresses)
    localparam logic [5:0] REG_INSTR = 6'h00;
    localparam logic [5:0] REG_ACC = 6'h04;
    localparam logic [5:0] REG_STATUS = 6'h08;
    localparam logic [5:0] REG_PC = 6'h0C;
    localparam logic [5:0] REG_PCHI = 6'h10;
    localparam logic [5:0] REG_FADDR = 6'h14;
    localparam logic [5:0] REG_FDATA = 6'h18;
    localparam logic [5:0] REG_IRQCTL = 6'h1C;
    localparam logic [5:0] REG_PIRA = 6'h20;
    localparam logic [5:0] REG_PIRB = 6'h24;
    // instruction word fields
    localparam int INSTR_OP_LSB = 0;
    localparam int INSTR_D_BIT = 4;
    localparam int INSTR_F_LSB = 8;
    localparam int INSTR_K_LSB = 16;
    // status bits
    localparam int ST_Z_BIT = 0;
    localparam int ST_BUSY_BIT = 1;
    localparam int ST_SLEEP_BIT = 2;
    // irq control bits
    localparam int IRQ_PEND_BIT = 0;
    localparam int IRQ_GIE_BIT = 7;
    // upper pc latch bits used by the jump
    localparam int PCHI_SEL_LSB = 3;
    // reset values
    localparam logic [12:0] PC_RST = 13'h0000;
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [4:0] PCHI_RST = 5'h00;
    localparam logic IRQ_GIE_RST = 1'b0;
    localparam logic Z_RST = 1'b0;
    // interrupt vector and timing
    localparam logic [12:0] IRQ_VECTOR = 13'h0004;
    localparam int OSC_PER_CYC = 4;
    localparam int EVT_W = 9;

    typedef enum logic [2:0] {
        OP_NOP, OP_DEC_SKIP, OP_INC_SKIP, OP_INC, OP_OR_LIT, OP_OR_FILE,
        OP_JUMP, OP_SLEEP
    } ides_op_t;

    typedef enum logic [1:0] {
        ST_IDLE, ST_WAIT, ST_SECOND, ST_SLEEP
    } ides_state_t;
endpackage : ides_pkg

`default_nettype wire
